// ==== verilog/sfps_core.sv ====
// serial flash protocol select front end: lane protocol, clock modes, lane drive
//
// Behaviour
// R1: sample incoming bits on rising clock edge
// R2: drive outgoing bits from falling clock edge
// R3: only idle-low mode 0 or idle-high mode 3
// R4: both clock modes in every protocol
// R5: unselected device leaves output lanes undriven
// R6: factory default extended, command on lane_zero
// R7: extended commands widen address/data per command
// R8: volatile bit6=0,bit7=1 selects dual protocol
// R9: volatile bit7=0 selects quad protocol
// R10: volatile protocol lost at power-on
// R11: rescue or new write returns default
// R12: persistent bit2 moved selects dual at boot
// R13: persistent bit3 zero selects quad at boot
// R14: persistent selection holds until bit restored
// R15: quad uses four lanes except supply-assisted cycles
// R16: supply-assisted cycle falls back to extended
// R17: quad resumes once supply pin low
// R18: host drives protect and hold inputs
// R19: host bus release longer than 5us
// R20: boot loads working config from persistent
// R21: configuration write copies into working config
// R22: protocol change waits for chip select high; a reboot loads the persistent protocol at once, even while selected
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module sfps_core
   import sfps_pkg::*;
(
   input  wire logic              clk_i,      // 200 MHz block clock
   input  wire logic              rst_n_i,    // synchronous reset, power-on
   input  wire sfps_pins_s        pins_i,     // raw pins from the bus
   output logic [3:0]             lane_o,     // lane output levels
   output logic [3:0]             lane_oe_o,  // lane output enables
   input  wire logic [ADDR_W-1:0] addr_i,     // register address
   input  wire logic [DATA_W-1:0] wdata_i,    // register write data
   input  wire logic              wr_i,       // write strobe
   input  wire logic              rd_i,       // read strobe
   output logic [DATA_W-1:0]      rdata_o     // read data, cycle after strobe
);

   // lanes used by one shift step
   function automatic logic [3:0] width_of(input sfps_proto_e p, input logic cmd_done,
                                          input logic [1:0] xl);
      logic [3:0] w;
      w = 4'h1;
      if (p == PROTO_QUAD) begin
         w = 4'h4;
      end else if (p == PROTO_DUAL) begin
         w = 4'h2;
      end else if (cmd_done && xl == 2'h1) begin
         w = 4'h2;
      end else if (cmd_done && xl == 2'h2) begin
         w = 4'h4;
      end
      return w;
   endfunction

   // shift lanes into a byte, most significant first
   function automatic logic [7:0] shift_in(input logic [7:0] b, input logic [3:0] d,
                                          input logic [3:0] w);
      logic [7:0] r;
      r = {b[6:0], d[0]};
      if (w == 4'h2) begin
         r = {b[5:0], d[1:0]};
      end else if (w == 4'h4) begin
         r = {b[3:0], d[3:0]};
      end
      return r;
   endfunction

   // lane protocol from an enhanced volatile value
   function automatic sfps_proto_e ev_proto(input logic [7:0] v);
      sfps_proto_e p;
      p = PROTO_EXT;
      if (!v[EV_QUAD_N]) begin
         p = PROTO_QUAD;
      end else if (!v[EV_DUAL_N]) begin
         p = PROTO_DUAL;
      end
      return p;
   endfunction

   // lane protocol from a persistent value
   function automatic sfps_proto_e pc_proto(input logic [15:0] v);
      sfps_proto_e p;
      p = PROTO_EXT;
      if (!v[PC_QUAD_N]) begin
         p = PROTO_QUAD;
      end else if (!v[PC_DUAL_N]) begin
         p = PROTO_DUAL;
      end
      return p;
   endfunction

   sfps_pins_s  pin_meta;    // first synchroniser stage
   sfps_pins_s  pin_sync;    // second synchroniser stage
   sfps_pins_s  pin_prev;    // delayed copy for edge detection
   sfps_proto_e active;      // working protocol
   sfps_proto_e pend;        // protocol waiting for deselect
   logic        pend_valid;  // a protocol change is waiting
   sfps_proto_e eff;         // protocol actually in use
   logic [15:0] pcfg;        // persistent configuration
   logic [7:0]  evcfg;       // enhanced volatile configuration
   logic [3:0]  ctrl;        // control bits
   logic [1:0]  xlanes;      // extended-protocol lanes after the command
   logic [7:0]  tx_data;     // byte software wants sent
   logic [7:0]  tx_shift;    // byte being sent
   logic [3:0]  tx_cnt;      // bits sent from tx_shift
   logic [7:0]  rx_shift;    // byte being received
   logic [3:0]  rx_cnt;      // bits received into rx_shift
   logic [7:0]  rx_data;     // last complete byte
   logic        rx_valid;    // unread byte present
   logic        cmd_done;    // first byte of this selection received
   logic        idle_high;   // clock level seen at select: mode 3
   logic        sclk_rise;   // rising serial clock while selected
   logic        sclk_fall;   // falling serial clock while selected
   logic        cs_fall;     // select begins
   logic [3:0]  width;       // lanes per step now
   logic [3:0]  next_rx_cnt;
   logic        rx_byte;     // a byte completes on this rising edge

   // two flip-flops on every pin before any logic reads it
   always_ff @(posedge clk_i) begin
      pin_meta <= pins_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
   end

   // edges; rising-edge sampling serves mode 0 and mode 3 alike
   assign sclk_rise   = pin_sync.sclk & ~pin_prev.sclk & ~pin_sync.cs_n;  // R1 R4
   assign sclk_fall   = ~pin_sync.sclk & pin_prev.sclk & ~pin_sync.cs_n;  // R2 R4
   assign cs_fall     = ~pin_sync.cs_n & pin_prev.cs_n;
   assign width       = width_of(eff, cmd_done, xlanes);                 // R6 R7 R15
   assign next_rx_cnt = rx_cnt + width;
   assign rx_byte     = sclk_rise && next_rx_cnt == BYTE_BITS;

   // quad falls back to extended while a supply-assisted cycle runs
   assign eff = (active == PROTO_QUAD && pin_sync.vpp && ctrl[CTRL_PE_BUSY]) ?
                PROTO_EXT : active;  // R15 R16 R17

   // working protocol: boot load, volatile writes, rescue
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         active     <= PROTO_EXT;  // R6 R10
         pend       <= PROTO_EXT;
         pend_valid <= 1'b0;
      end else if (wr_i && addr_i == REG_CTRL && wdata_i[CTRL_REBOOT]) begin
         active     <= pc_proto(pcfg);  // R10 R12 R13 R14 R20
         pend_valid <= 1'b0;
      end else if (wr_i && addr_i == REG_CTRL && wdata_i[CTRL_RESCUE]) begin
         pend       <= PROTO_EXT;  // R11
         pend_valid <= 1'b1;
      end else if (wr_i && addr_i == REG_EVCFG) begin
         pend       <= ev_proto(wdata_i[7:0]);  // R8 R9 R11 R21
         pend_valid <= 1'b1;
      end else if (pend_valid && pin_sync.cs_n) begin
         // a change made mid-command would corrupt the rest of that command
         active     <= pend;  // R22
         pend_valid <= 1'b0;
      end
   end

   // software registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pcfg    <= PCFG_RST;
         evcfg   <= EVCFG_RST;
         ctrl    <= CTRL_RST;
         xlanes  <= XLANES_RST;
         tx_data <= BYTE_RST;
      end else if (wr_i) begin
         unique case (addr_i)
            REG_CTRL: begin
               // rescue and reboot are pulses and never stored
               ctrl <= {wdata_i[CTRL_PE_BUSY], 2'b00, wdata_i[CTRL_TX_EN]};
            end
            REG_EVCFG:  evcfg   <= wdata_i[7:0];
            REG_PCFG:   pcfg    <= wdata_i;         // R14
            REG_XLANES: xlanes  <= wdata_i[1:0];    // R7
            REG_TX:     tx_data <= wdata_i[7:0];
            default: begin
               // read-only or unmapped: ignored
            end
         endcase
      end
   end

   // receive path, sampled on rising serial clock only
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_shift <= BYTE_RST;
         rx_cnt   <= 4'h0;
         cmd_done <= 1'b0;
         rx_data  <= BYTE_RST;
      end else if (cs_fall) begin
         rx_cnt   <= 4'h0;
         cmd_done <= 1'b0;
      end else if (sclk_rise) begin
         rx_shift <= shift_in(rx_shift, pin_sync.lane, width);  // R1
         rx_cnt   <= rx_byte ? 4'h0 : next_rx_cnt;
         if (rx_byte) begin
            rx_data  <= shift_in(rx_shift, pin_sync.lane, width);
            cmd_done <= 1'b1;  // R6 R7
         end
      end
   end

   // unread flag: a new byte wins over a read in the same cycle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_valid <= 1'b0;
      end else if (rx_byte) begin
         rx_valid <= 1'b1;
      end else if (rd_i && addr_i == REG_RX) begin
         rx_valid <= 1'b0;
      end
   end

   // idle clock level at select tells which of the two modes the host uses
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         idle_high <= 1'b0;
      end else if (cs_fall) begin
         idle_high <= pin_sync.sclk;  // R3
      end
   end

   // transmit path, driven from falling serial clock, undriven when deselected
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || pin_sync.cs_n) begin
         lane_o    <= 4'h0;
         lane_oe_o <= 4'h0;  // R5
         tx_shift  <= tx_data;
         tx_cnt    <= 4'h0;
      end else if (sclk_fall && ctrl[CTRL_TX_EN] && cmd_done) begin
         // extended output leaves on lane one; dual adds lane zero below it, quad drives all four lanes with the msb on lane three
         lane_o    <= (width == 4'h4) ? tx_shift[7:4] :
                      (width == 4'h2) ? {2'b00, tx_shift[7:6]} : {2'b00, tx_shift[7], 1'b0};
         lane_oe_o <= (width == 4'h4) ? 4'hF : (width == 4'h2) ? 4'h3 : 4'h2;  // R2
         if (tx_cnt + width == BYTE_BITS) begin
            tx_shift <= tx_data;
            tx_cnt   <= 4'h0;
         end else begin
            tx_shift <= (width == 4'h4) ? {tx_shift[3:0], 4'h0} :
                        (width == 4'h2) ? {tx_shift[5:0], 2'b00} : {tx_shift[6:0], 1'b0};
            tx_cnt   <= tx_cnt + width;
         end
      end else if (!ctrl[CTRL_TX_EN]) begin
         lane_oe_o <= 4'h0;
      end
   end

   // read data stands in the cycle after the strobe only
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !rd_i) begin
         rdata_o <= 16'h0000;
      end else begin
         unique case (addr_i)
            REG_CTRL:   rdata_o <= {12'h000, ctrl};
            REG_EVCFG:  rdata_o <= {8'h00, evcfg};
            REG_PCFG:   rdata_o <= pcfg;
            REG_XLANES: rdata_o <= {14'h0000, xlanes};
            REG_TX:     rdata_o <= {8'h00, tx_data};
            REG_RX:     rdata_o <= {8'h00, rx_data};
            REG_STAT: begin
               rdata_o <= {9'h000, pend_valid, idle_high, ~pin_sync.cs_n,
                           rx_valid, 1'b0, eff};
            end
            default:    rdata_o <= 16'h0000;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_ev_write(logic [7:0] v);
      wr_i && addr_i == REG_EVCFG && wdata_i[7:0] == v;
   endsequence
   sequence s_idle;
      pin_sync.cs_n && !(wr_i && addr_i == REG_CTRL);
   endsequence

   property p_r1;
      !sclk_rise && !cs_fall |=> $stable(rx_shift);
   endproperty
   a_r1: assert property (p_r1) else $error("receive shifted without rising clock"); // R1

   property p_r2;
      !sclk_fall && !pin_sync.cs_n && $stable(ctrl) |=> $stable(lane_o);
   endproperty
   a_r2: assert property (p_r2) else $error("lane drive changed off falling edge"); // R2

   property p_r5;
      pin_sync.cs_n |=> lane_oe_o == 4'h0;
   endproperty
   a_r5: assert property (p_r5) else $error("lane driven while deselected"); // R5

   property p_r8;
      s_ev_write(8'hBF) ##1 s_idle [*2] |-> active == PROTO_DUAL;
   endproperty
   a_r8: assert property (p_r8) else $error("dual not selected"); // R8

   property p_r9;
      s_ev_write(8'h7F) ##1 s_idle [*2] |-> active == PROTO_QUAD;
   endproperty
   a_r9: assert property (p_r9) else $error("quad not selected"); // R9

   property p_r11;
      s_ev_write(8'hFF) ##1 s_idle [*2] |-> active == PROTO_EXT;
   endproperty
   a_r11: assert property (p_r11) else $error("default not restored"); // R11

   property p_r22;
      !pin_sync.cs_n && active != PROTO_EXT |=> $stable(active) || $past(wr_i);
   endproperty
   a_r22: assert property (p_r22) else $error("protocol changed mid-command"); // R22

   property p_r16;
      active == PROTO_QUAD && pin_sync.vpp && ctrl[CTRL_PE_BUSY] |-> width_of(eff, 1'b0,
         2'h0) == 4'h1;
   endproperty
   a_r16: assert property (p_r16) else $error("no fallback during supply cycle"); // R16

   property p_r17;
      active == PROTO_QUAD && !pin_sync.vpp |-> eff == PROTO_QUAD;
   endproperty
   a_r17: assert property (p_r17) else $error("quad not resumed"); // R17

   property p_r20;
      wr_i && addr_i == REG_CTRL && wdata_i[CTRL_REBOOT] && !pcfg[PC_QUAD_N] |=>
         active == PROTO_QUAD;
   endproperty
   a_r20: assert property (p_r20) else $error("boot did not load persistent quad"); // R20 R13

   // the idle clock level is latched from the select edge itself
   property p_r3;
      cs_fall |=> idle_high == $past(pin_sync.sclk);
   endproperty
   a_r3: assert property (p_r3) else $error("idle clock level not recorded"); // R3

   // a quad output step enables all four lanes at once
   property p_r15;
      sclk_fall && ctrl[CTRL_TX_EN] && cmd_done && width == 4'h4 |=> lane_oe_o == 4'hF;
   endproperty
   a_r15: assert property (p_r15) else $error("quad output not on four lanes"); // R15

endmodule

// ==== pkg/sfps_pkg.sv ====
// shared constants and types of the serial flash protocol select front end
package sfps_pkg;
   // register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   // register offsets
   localparam logic [3:0] REG_CTRL   = 4'h0;  // control bits
   localparam logic [3:0] REG_EVCFG  = 4'h1;  // enhanced volatile configuration
   localparam logic [3:0] REG_PCFG   = 4'h2;  // persistent configuration
   localparam logic [3:0] REG_XLANES = 4'h3;  // extended protocol lane count
   localparam logic [3:0] REG_TX     = 4'h4;  // outgoing byte
   localparam logic [3:0] REG_RX     = 4'h5;  // last received byte
   localparam logic [3:0] REG_STAT   = 4'h6;  // block state
   // control field positions
   localparam int CTRL_TX_EN   = 0;  // drive outgoing bytes while selected
   localparam int CTRL_RESCUE  = 1;  // write 1: back to extended protocol
   localparam int CTRL_REBOOT  = 2;  // write 1: reload from persistent setting
   localparam int CTRL_PE_BUSY = 3;  // program or erase cycle running
   // enhanced volatile and persistent configuration field positions
   localparam int EV_DUAL_N = 6;
   localparam int EV_QUAD_N = 7;
   localparam int PC_DUAL_N = 2;
   localparam int PC_QUAD_N = 3;
   // reset values
   localparam logic [15:0] PCFG_RST   = 16'hFFFF;
   localparam logic [7:0]  EVCFG_RST  = 8'hFF;
   localparam logic [7:0]  BYTE_RST   = 8'h00;
   localparam logic [3:0]  CTRL_RST   = 4'h0;
   localparam logic [1:0]  XLANES_RST = 2'h0;
   // bits in one transfer unit
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // lane protocol
   typedef enum logic [1:0] {
      PROTO_EXT  = 2'b00,
      PROTO_DUAL = 2'b01,
      PROTO_QUAD = 2'b10
   } sfps_proto_e;

   // pins that arrive from outside the clock domain
   typedef struct packed {
      logic       sclk;      // serial clock
      logic       cs_n;      // chip select, active low
      logic       vpp;       // high-voltage supply pin level
      logic [3:0] lane;      // data lanes, lane_zero at bit 0
   } sfps_pins_s;
endpackage

// ==== verif/sfps_host_model.sv ====
// host model that drives the serial bus pins of the flash front end
`timescale 1ns/1ps
module sfps_host_model
   import sfps_pkg::*;
(
   output sfps_pins_s       pins_o,    // bus pins toward the device
   input  wire logic [3:0]  lane_i,    // device lane levels
   input  wire logic [3:0]  lane_oe_i  // device lane enables
);
   logic       sclk = 1'b0;  // serial clock, stands still between frames
   logic       cs_n = 1'b1;  // select is always driven, never floated
   logic       vpp  = 1'b0;  // supply pin held at a definite level
   logic [3:0] hval = 4'h0;  // levels the host puts on its lanes
   logic [3:0] hen  = 4'h0;  // lanes the host drives
   logic [3:0] lvl;          // resolved lane levels

   // a lane nobody drives shows the inverse level, so stale data cannot pass
   always_comb begin
      for (int i = 0; i < 4; i++)
         lvl[i] = lane_oe_i[i] ? lane_i[i] : (hen[i] ? hval[i] : ~lane_i[i]);
   end
   assign pins_o = '{sclk: sclk, cs_n: cs_n, vpp: vpp, lane: lvl};

   // clock idles at the mode level before select falls
   task automatic select(input logic cpol);
      #0.5 sclk = cpol;
      #24 cs_n = 1'b0;
      #24;
   endtask

   // one byte, msb first; host changes data low, samples on the rising edge
   task automatic xfer(input int w, input logic [7:0] tx, input logic drv,
                       output logic [7:0] rx);
      for (int i = 0; i < 8 / w; i++) begin
         sclk = 1'b0;
         hen  = 4'h0;
         for (int b = 0; b < w; b++) begin
            hval[b] = tx[8 - (i + 1) * w + b];
            hen[b]  = drv;
         end
         #24 sclk = 1'b1;
         // single lane width answers on lane one
         for (int b = 0; b < w; b++)
            rx[8 - (i + 1) * w + b] = lvl[(w == 1) ? 1 : b];
         #24;
      end
   endtask

   // end of frame: clock back to its idle level, then release select
   task automatic deselect(input logic cpol);
      sclk = cpol;
      #24 cs_n = 1'b1;
      hen = 4'h0;
      #24;
   endtask
endmodule

// ==== verif/sfps_core_tb.sv ====
// self-checking bench of the flash protocol select front end
`timescale 1ns/1ps
module sfps_core_tb
   import sfps_pkg::*;
;
   logic              clk_i   = 1'b0;
   logic              rst_n_i = 1'b0;
   sfps_pins_s        pins;
   logic [3:0]        lane_o, lane_oe_o;
   logic [ADDR_W-1:0] addr_i  = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic [DATA_W-1:0] rdata_o;
   logic              wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
   int                bad_count = 0, num_checks = 0;
   logic [15:0]       exp_q[$], msk_q[$];  // pending read expectations
   logic [7:0]        tx, cmd, got;

   always #2.5 clk_i = ~clk_i;

   sfps_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .lane_o(lane_o),
                  .lane_oe_o(lane_oe_o), .addr_i(addr_i), .wdata_i(wdata_i),
                  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
   sfps_host_model host (.pins_o(pins), .lane_i(lane_o), .lane_oe_i(lane_oe_o));

   task automatic check(input string nm, input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask

   // note the expected value, then issue the read
   task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
      @(posedge clk_i);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
   endtask

   // read data stand one cycle only, so look at them mid-cycle
   always @(posedge clk_i) rd_seen <= rd_i;
   always @(negedge clk_i) begin
      if (rd_seen)
         check("rdata", rdata_o & msk_q.pop_front(), exp_q.pop_front());
   end

   task automatic reset();
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
   endtask

   // command byte at width w, mid-frame receive check, then a second byte
   task automatic frame(input logic cpol, input int w, w2, input logic drv2);
      cmd = 8'($urandom);
      tx  = 8'($urandom);
      wr(REG_TX, {8'h00, tx});
      host.select(cpol);
      repeat (2) @(posedge clk_i);
      rd(REG_STAT, {10'h0, cpol, 1'b1, 4'h0}, 16'h0030);
      host.xfer(w, cmd, 1'b1, got);
      repeat (6) @(posedge clk_i);
      rd(REG_RX, {8'h00, cmd}, 16'h00FF);
      rd(REG_STAT, 16'h0000, 16'h0008);
      host.xfer(w2, tx, drv2, got);
      host.deselect(cpol);
      repeat (4) @(posedge clk_i);
      check("lane_oe", {12'h0, lane_oe_o}, 16'h0000);
      rd(REG_STAT, 16'h0008, 16'h0008);
   endtask

   initial begin
      static logic [15:0] rv [8] = '{16'h0, 16'h00FF, 16'hFFFF, 16'h0,
                                     16'h0, 16'h0, 16'h0, 16'h0};
      static logic [7:0]  ev [3] = '{8'hFF, 8'hBF, 8'h7F};
      static logic [15:0] pc [4] = '{16'hFFFB, 16'hFFF7, 16'hFFF3, 16'hFFFF};
      static logic [1:0]  pp [4] = '{2'd1, 2'd2, 2'd2, 2'd0};
      void'($urandom(32'hd0ad));
      reset();
      wr(REG_STAT, 16'hFFFF);  // read-only places take no write
      wr(REG_RX, 16'h00AA);
      for (int a = 0; a < 8; a++)
         rd(a[3:0], rv[a], 16'hFFFF);
      wr(REG_CTRL, 16'h0001);
      // both clock modes in every lane protocol
      for (int m = 0; m < 2; m++) begin
         for (int p = 0; p < 3; p++) begin
            wr(REG_EVCFG, {8'h00, ev[p]});
            repeat (8) @(posedge clk_i);
            rd(REG_STAT, {14'h0, p[1:0]}, 16'h0003);
            frame(m[0], 1 << p, 1 << p, p == 0);
            check("tx_byte", {8'h0, got}, {8'h0, tx});
         end
      end
      // a change written while selected waits for the frame to end
      host.select(1'b0);
      wr(REG_EVCFG, 16'h00BF);
      repeat (4) @(posedge clk_i);
      rd(REG_STAT, 16'h0042, 16'h0043);
      host.deselect(1'b0);
      repeat (8) @(posedge clk_i);
      rd(REG_STAT, 16'h0001, 16'h0043);
      wr(REG_CTRL, 16'h0003);
      repeat (8) @(posedge clk_i);
      rd(REG_STAT, 16'h0000, 16'h0003);
      // supply high alone keeps quad; with a cycle running it falls back
      wr(REG_EVCFG, 16'h007F);
      #0.5 host.vpp = 1'b1;
      repeat (8) @(posedge clk_i);
      rd(REG_STAT, 16'h0002, 16'h0003);
      wr(REG_CTRL, 16'h0009);
      repeat (8) @(posedge clk_i);
      rd(REG_STAT, 16'h0000, 16'h0003);
      frame(1'b0, 1, 1, 1'b1);
      check("fallback_byte", {8'h0, got}, {8'h0, tx});
      #0.5 host.vpp = 1'b0;
      repeat (8) @(posedge clk_i);
      rd(REG_STAT, 16'h0002, 16'h0003);
      reset();
      rd(REG_STAT, 16'h0000, 16'h0003);
      rd(REG_EVCFG, 16'h00FF, 16'hFFFF);
      for (int k = 0; k < 4; k++) begin
         wr(REG_PCFG, pc[k]);
         wr(REG_CTRL, 16'h0004);
         repeat (8) @(posedge clk_i);
         rd(REG_STAT, {14'h0, pp[k]}, 16'h0003);
      end
      // wider data phases in extended mode; lanes one up belong to the host
      wr(REG_CTRL, 16'h0000);
      for (int x = 1; x < 3; x++) begin
         wr(REG_XLANES, x[15:0]);
         frame(1'b1, 1, 2 * x, 1'b1);
         rd(REG_RX, {8'h00, tx}, 16'h00FF);
      end
      finish_test();
   end

   // hang guard, well beyond the expected run length
   initial begin
      #200_000;
      bad_count++;
      finish_test();
   end
endmodule
